// [rtl/ebc_bus_ctrl.sv]
// Purpose: external bus control: hold, ready stretch, strobe, clock pin, debug outputs
// Assumes: all inputs synchronous to clk; internal clock runs at half of clk
// Notes:   bus terms advance on the falling edge of the internal clock
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1: Hold taken at internal clock fall, bus idle
// RQ2: Hold grant output driven low on hold
// RQ3: Bus pins float one cycle after grant
// RQ4: Bus pins driven one cycle after release
// RQ5: Low ready halts internal clock at low
// RQ6: Clock output keeps toggling despite ready
// RQ7: Port latch replaces clock when disabled
// RQ8: Disable bit hides strobe on internal accesses
// RQ9: Standby strobe level follows disable bit
// RQ10: Evaluation high lane: address, odd data
// RQ11: Evaluation low lane follows width pin
// RQ12: External data ignored on internal reads
// RQ13: Evaluation auxiliary port: 16-bit, internal timing
// RQ14: Evaluation mode always outputs the clock
// RQ15: Evaluation mode remaps auxiliary port bits
// RQ16: Width flag shows index or data flag
// RQ17: Queue flush output marks queue clear
// RQ18: Valid data address on buffer access, opcode
// RQ19: Valid program address on code fetch
// RQ20: Reset ends when reset input rises
// RQ21: Start address from vector, bank zero
// RQ22: Strobe low only in data terms; the code also drives it low in standby outside accesses (RQ9)
// RQ23: Grant released only after request drops
module ebc_bus_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mode_select_pin,
  input  wire logic        byte_width_pin,
  input  wire logic        hold_req_n,
  input  wire logic        ready_n,
  output logic             hold_grant_n,
  output logic             bus_strobe_n,
  output logic             rw_out,
  output logic             upper_byte_enable_n,
  output logic             ctrl_pins_oe,
  output logic [7:0]       addr_low_out,
  input  wire logic [7:0]  mid_lane_in,
  output logic [7:0]       mid_lane_out,
  output logic             mid_lane_oe,
  input  wire logic [7:0]  low_address_data_lane_in,
  output logic [7:0]       low_address_data_lane_out,
  output logic             low_address_data_lane_oe,
  output logic             clock_out_pin,
  output logic             clock_out_oe,
  output logic [3:0]       auxiliary_port_out,
  output logic [3:0]       auxiliary_port_oe,
  input  wire logic        debug_control_in,
  output logic             phi_fall,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [23:0] req_addr,
  input  wire logic        req_write,
  input  wire logic        req_word,
  input  wire logic        req_internal,
  input  wire logic [15:0] req_wdata,
  input  wire logic [15:0] internal_rdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             start_valid,
  output logic [23:0]      start_addr,
  input  wire logic        wait_instruction,
  input  wire logic        stop_instruction,
  input  wire logic        cpu_m_flag,
  input  wire logic        cpu_x_flag,
  input  wire logic        cpu_x_in_use,
  input  wire logic        cpu_queue_flush,
  input  wire logic        cpu_data_buf_access,
  input  wire logic        cpu_opcode_fetch,
  input  wire logic        cpu_program_fetch
);

  ebc_pkg::ebc_regs_type s_q;
  ebc_pkg::ebc_regs_type s_d;
  logic        wide;
  logic        show;
  logic        dterm;
  logic        in_acc;
  logic        standby;
  logic        aux_eval;
  logic [15:0] din;
  logic [15:0] nrd;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  // ----------------------------------------
  // Handshakes and registered outputs
  // ----------------------------------------
  // Hold has priority over a new request at the same fall
  assign req_ready     = (s_q.st == ebc_pkg::ST_IDLE) && s_q.phi && hold_req_n && s_q.vec_done;
  assign phi_fall      = s_q.phi;
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata_axi;
  assign s_axi_rresp   = s_q.rresp;
  assign hold_grant_n        = s_q.grant_n;
  assign bus_strobe_n        = s_q.strobe_n;
  assign rw_out              = s_q.rw;
  assign upper_byte_enable_n = s_q.ube_n;
  assign ctrl_pins_oe        = !s_q.float_bus;
  assign addr_low_out        = s_q.a_lo;
  assign mid_lane_out        = s_q.mid_o;
  assign mid_lane_oe         = s_q.mid_oe;
  assign low_address_data_lane_out = s_q.lo_o;
  assign low_address_data_lane_oe  = s_q.lo_oe;
  assign clock_out_pin       = s_q.clk_pin;
  assign clock_out_oe        = s_q.clk_pin_oe;
  assign auxiliary_port_out  = s_q.aux_o;
  assign auxiliary_port_oe   = s_q.aux_oe;
  assign rsp_valid           = s_q.rsp_valid;
  assign rsp_rdata           = s_q.rdata;
  assign start_valid         = s_q.start_valid;
  assign start_addr          = s_q.start_addr;

  always_comb begin
    s_d      = s_q;
    wide     = 1'b0;
    show     = 1'b0;
    dterm    = 1'b0;
    in_acc   = 1'b0;
    standby  = wait_instruction || stop_instruction;
    aux_eval = 1'b0;
    din      = 16'h0000;
    nrd      = s_q.rdata;
    rd_word  = 32'h0000_0000;
    rd_resp  = ebc_pkg::RESP_OKAY;
    s_d.rsp_valid   = 1'b0;
    s_d.start_valid = 1'b0;

    // ----------------------------------------
    // Strap and clocks
    // ----------------------------------------
    // Mode pin caught once, first cycle after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.eval       = mode_select_pin;
    end
    s_d.clk1 = !s_q.clk1; // RQ6
    s_d.phi  = !s_q.phi && ready_n; // RQ5

    // ----------------------------------------
    // Bus engine, one step per internal clock fall
    // ----------------------------------------
    wide = s_q.acc_internal || !byte_width_pin;
    if (s_q.phi) begin
      case (s_q.st)
        ebc_pkg::ST_IDLE: begin
          if (!hold_req_n) begin
            s_d.grant_n = 1'b0; // RQ1
            s_d.st      = ebc_pkg::ST_HOLD_ENTER; // RQ2
          end else if (s_q.strap_done && !s_q.vec_done) begin
            // Reset vector read, started once after reset release
            s_d.acc_addr     = ebc_pkg::VEC_ADDR; // RQ20
            s_d.acc_write    = 1'b0;
            s_d.acc_word     = 1'b1;
            s_d.acc_internal = 1'b0;
            s_d.acc_vec      = 1'b1;
            s_d.second       = 1'b0;
            s_d.waited       = 1'b0;
            s_d.st           = ebc_pkg::ST_ADDR;
          end else if (req_valid) begin
            aux_eval = s_q.eval && (req_addr == ebc_pkg::AUX_DATA_ADDR ||
                                    req_addr == ebc_pkg::AUX_DIR_ADDR);
            s_d.acc_addr     = req_word ? {req_addr[23:1], 1'b0} : req_addr;
            s_d.acc_write    = req_write;
            s_d.acc_word     = req_word;
            s_d.acc_internal = req_internal || aux_eval; // RQ13
            s_d.acc_wdata    = req_wdata;
            s_d.acc_vec      = 1'b0;
            s_d.second       = 1'b0;
            s_d.waited       = 1'b0;
            s_d.st           = ebc_pkg::ST_ADDR;
          end
        end
        ebc_pkg::ST_ADDR: begin
          s_d.st = ebc_pkg::ST_DATA;
        end
        ebc_pkg::ST_DATA: begin
          if (!s_q.acc_internal && !s_q.wait_bit && !s_q.waited) begin
            s_d.waited = 1'b1;
          end else begin
            // Internal reads never look at the lanes
            if (s_q.acc_internal) begin
              din = internal_rdata; // RQ12
            end else if (wide) begin
              din = {mid_lane_in, low_address_data_lane_in};
            end else begin
              din = {low_address_data_lane_in, low_address_data_lane_in};
            end
            if (s_q.acc_word && wide) begin
              nrd = din;
            end else if (s_q.acc_addr[0]) begin
              nrd[15:8] = din[15:8];
            end else begin
              nrd[7:0] = din[7:0];
            end
            if (!s_q.acc_write) begin
              s_d.rdata = nrd;
            end
            if (s_q.acc_word && !wide && !s_q.second) begin
              // Narrow bus: word done as even byte, then odd byte
              s_d.second   = 1'b1;
              s_d.waited   = 1'b0;
              s_d.acc_addr = {s_q.acc_addr[23:1], 1'b1};
              s_d.st       = ebc_pkg::ST_ADDR;
            end else begin
              s_d.st = ebc_pkg::ST_IDLE;
              if (s_q.acc_vec) begin
                s_d.start_addr  = {ebc_pkg::START_BANK, nrd[15:8], nrd[7:0]}; // RQ21
                s_d.vec_done    = 1'b1;
                s_d.start_valid = 1'b1;
              end else begin
                s_d.rsp_valid = 1'b1;
              end
            end
          end
        end
        ebc_pkg::ST_HOLD_ENTER: begin
          s_d.float_bus = 1'b1; // RQ3
          s_d.st        = ebc_pkg::ST_HOLD;
        end
        ebc_pkg::ST_HOLD: begin
          if (hold_req_n) begin
            s_d.grant_n = 1'b1; // RQ23
            s_d.st      = ebc_pkg::ST_HOLD_EXIT;
          end
        end
        ebc_pkg::ST_HOLD_EXIT: begin
          s_d.float_bus = 1'b0; // RQ4
          s_d.st        = ebc_pkg::ST_IDLE;
        end
        default: begin
          s_d.st = ebc_pkg::ST_IDLE;
        end
      endcase
    end

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = ebc_pkg::RESP_OKAY;
      case (s_q.awaddr)
        ebc_pkg::REG_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.sod       = s_q.wdata[ebc_pkg::CTRL_SOD_BIT];
            s_d.clk_latch = s_q.wdata[ebc_pkg::CTRL_LATCH_BIT];
            s_d.clk_dir   = s_q.wdata[ebc_pkg::CTRL_DIR_BIT];
            s_d.stby_sel  = s_q.wdata[ebc_pkg::CTRL_STBY_BIT];
            s_d.wait_bit  = s_q.wdata[ebc_pkg::CTRL_WAIT_BIT];
          end
        end
        ebc_pkg::REG_AUX: begin
          if (s_q.wstrb[0]) begin
            s_d.aux_latch = s_q.wdata[ebc_pkg::AUX_LATCH_LSB +: 4];
            s_d.aux_dir   = s_q.wdata[ebc_pkg::AUX_DIR_LSB +: 4];
          end
        end
        ebc_pkg::REG_STATUS, ebc_pkg::REG_START: begin
          s_d.bresp = ebc_pkg::RESP_OKAY;
        end
        default: begin
          s_d.bresp = ebc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    case (s_axi_araddr)
      ebc_pkg::REG_CTRL: begin
        rd_word[4:0] = {s_q.wait_bit, s_q.stby_sel, s_q.clk_dir, s_q.clk_latch, s_q.sod};
      end
      ebc_pkg::REG_AUX: begin
        rd_word[7:0] = {s_q.aux_dir, s_q.aux_latch};
      end
      ebc_pkg::REG_STATUS: begin
        rd_word[7:0] = {byte_width_pin, standby, s_q.vec_done, debug_control_in,
                        ready_n, s_q.float_bus, !s_q.grant_n, s_q.eval};
      end
      ebc_pkg::REG_START: begin
        rd_word[23:0] = s_q.start_addr;
      end
      default: begin
        rd_resp = ebc_pkg::RESP_SLVERR;
      end
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid    = 1'b1;
      s_d.rdata_axi = rd_word;
      s_d.rresp     = rd_resp;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ----------------------------------------
    // Pin values from the next state
    // ----------------------------------------
    in_acc = (s_d.st == ebc_pkg::ST_ADDR) || (s_d.st == ebc_pkg::ST_DATA);
    dterm  = (s_d.st == ebc_pkg::ST_DATA);
    wide   = s_d.acc_internal || !byte_width_pin;
    show   = !(s_d.acc_internal && s_d.sod && !s_d.eval); // RQ8
    if (in_acc) begin
      s_d.strobe_n = !(dterm && show); // RQ22
    end else begin
      s_d.strobe_n = !(standby && s_d.sod && s_d.stby_sel && !s_d.eval); // RQ9
    end
    s_d.rw    = !(in_acc && s_d.acc_write);
    s_d.ube_n = !(in_acc && (s_d.acc_addr[0] || (s_d.acc_word && wide)));
    s_d.a_lo  = s_d.acc_addr[7:0];
    // High lane: data only on 16-bit or evaluation odd bytes
    if (dterm && s_d.acc_write && (wide || (s_d.eval && s_d.acc_addr[0]))) begin
      s_d.mid_o = s_d.acc_wdata[15:8]; // RQ10
    end else begin
      s_d.mid_o = s_d.acc_addr[15:8];
    end
    s_d.mid_oe = !s_d.float_bus && !(dterm && !s_d.acc_write && (wide || s_d.eval));
    if (dterm && s_d.acc_write) begin
      s_d.lo_o = (!wide && s_d.acc_addr[0]) ? s_d.acc_wdata[15:8] : s_d.acc_wdata[7:0]; // RQ11
    end else begin
      s_d.lo_o = s_d.acc_addr[23:16];
    end
    s_d.lo_oe = !s_d.float_bus && !(dterm && !s_d.acc_write);
    if (!s_d.eval && s_d.sod && s_d.clk_dir) begin
      s_d.clk_pin = s_d.clk_latch; // RQ7
    end else begin
      s_d.clk_pin = s_d.clk1; // RQ14
    end
    s_d.clk_pin_oe = s_d.eval || !s_d.sod || s_d.clk_dir;
    if (s_d.eval) begin
      s_d.aux_o  = {cpu_program_fetch, // RQ19
                    cpu_data_buf_access || cpu_opcode_fetch, // RQ18
                    cpu_queue_flush, // RQ17
                    cpu_x_in_use ? cpu_x_flag : cpu_m_flag}; // RQ16
      s_d.aux_oe = 4'hF; // RQ15
    end else begin
      s_d.aux_o  = s_d.aux_latch;
      s_d.aux_oe = s_d.aux_dir;
    end
  end

  // Reset is synchronous; the engine waits for its release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= ebc_pkg::RESET_STATE; // RQ20
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_ready_stops_phi: assert property ((!s_q.phi && !ready_n) |=> !s_q.phi) // RQ5
    else $error("internal clock rose while ready was low");
  a_clk_out_free: assert property (!ready_n |=> (s_q.clk1 != $past(s_q.clk1))) // RQ6
    else $error("clock output stalled by ready");
  a_port_latch_pin: assert property ((!s_q.eval && s_q.sod && s_q.clk_dir)
    |-> (clock_out_pin == s_q.clk_latch)) // RQ7
    else $error("clock pin not showing port latch");
  a_eval_clock_pin: assert property (s_q.eval |-> ##1 (clock_out_pin != $past(clock_out_pin))) // RQ14
    else $error("clock pin not toggling in evaluation mode");
  a_hold_accept: assert property ($fell(hold_grant_n)
    |-> $past(!hold_req_n && s_q.phi && s_q.st == ebc_pkg::ST_IDLE)) // RQ1
    else $error("hold granted outside an idle clock fall");
  a_float_after_grant: assert property ($fell(hold_grant_n) |-> ctrl_pins_oe ##1 ctrl_pins_oe) // RQ3
    else $error("bus floated too early after grant");
  a_float_late: assert property ($fell(ctrl_pins_oe)
    |-> (!hold_grant_n && $past(!hold_grant_n, 2))) // RQ3
    else $error("bus floated without a full cycle of grant");
  a_drive_after_rel: assert property ($rose(ctrl_pins_oe)
    |-> (hold_grant_n && $past(hold_grant_n, 2))) // RQ4
    else $error("bus driven before a full cycle of release");
  a_release_needs_req: assert property ($rose(hold_grant_n) |-> $past(hold_req_n)) // RQ23
    else $error("grant released while request still low");
  a_internal_strobe: assert property ((s_q.st == ebc_pkg::ST_DATA && s_q.acc_internal
    && s_q.sod && !s_q.eval) |-> bus_strobe_n) // RQ8
    else $error("strobe pulsed on hidden internal access");
  a_standby_strobe: assert property ((s_q.st == ebc_pkg::ST_IDLE && s_q.sod && s_q.stby_sel
    && !s_q.eval && $past(wait_instruction || stop_instruction)) |-> !bus_strobe_n) // RQ9
    else $error("strobe not low in standby");
  a_strobe_term: assert property ((s_q.st == ebc_pkg::ST_ADDR || (s_q.st == ebc_pkg::ST_DATA && !s_q.acc_internal))
    |-> (bus_strobe_n == (s_q.st == ebc_pkg::ST_ADDR))) // RQ22
    else $error("strobe low outside a data term");
  a_width_flag: assert property (s_q.eval |-> (auxiliary_port_out[0] ==
    ($past(cpu_x_in_use) ? $past(cpu_x_flag) : $past(cpu_m_flag)))) // RQ16
    else $error("width flag shows the wrong flag");
  a_vector_bank: assert property (s_q.start_valid
    |-> (s_q.start_addr[23:16] == 8'h00 && s_q.vec_done && !$past(s_q.vec_done))) // RQ21
    else $error("start address bank not zero");

endmodule // ebc_bus_ctrl

`default_nettype wire

// [rtl/ebc_pkg.sv]
// Purpose: constants and types for the external bus control block
// Assumes: one 125 MHz clock, AXI4-Lite register access
// Notes:   all widths fixed; state lives in one packed struct
package ebc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_AUX    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_START  = 8'h0C;

  // Control register fields
  localparam int CTRL_SOD_BIT   = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_DIR_BIT   = 2;
  localparam int CTRL_STBY_BIT  = 3;
  localparam int CTRL_WAIT_BIT  = 4;

  // Auxiliary port register fields
  localparam int AUX_LATCH_LSB = 0;
  localparam int AUX_DIR_LSB   = 4;

  // ----------------------------------------
  // Fixed addresses and answers
  // ----------------------------------------
  localparam logic [23:0] VEC_ADDR      = 24'h00FFFE;
  localparam logic [23:0] AUX_DATA_ADDR = 24'h00000A;
  localparam logic [23:0] AUX_DIR_ADDR  = 24'h00000C;
  localparam logic [7:0]  START_BANK    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD_ENTER, ST_HOLD, ST_HOLD_EXIT
  } ebc_bus_state_type;

  typedef struct packed {
    ebc_bus_state_type st;
    logic        strap_done, eval, vec_done, phi, clk1;
    logic        grant_n, float_bus, waited, second;
    logic        rsp_valid, start_valid;
    logic [23:0] acc_addr;
    logic        acc_write, acc_word, acc_internal, acc_vec;
    logic [15:0] acc_wdata, rdata;
    logic [23:0] start_addr;
    logic        sod, clk_latch, clk_dir, stby_sel, wait_bit;
    logic [3:0]  aux_latch, aux_dir;
    logic        strobe_n, rw, ube_n;
    logic        mid_oe, lo_oe;
    logic [7:0]  a_lo, mid_o, lo_o;
    logic        clk_pin, clk_pin_oe;
    logic [3:0]  aux_o, aux_oe;
    logic        aw_got, w_got, bvalid, rvalid;
    logic [7:0]  awaddr;
    logic [31:0] wdata, rdata_axi;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
  } ebc_regs_type;

  localparam ebc_regs_type RESET_STATE = '{st: ST_IDLE, grant_n: 1'b1, strobe_n: 1'b1,
                                           rw: 1'b1, ube_n: 1'b1, default: '0};

endpackage

// [tb/ebc_mem_model.sv]
// Purpose: external memory partner with optional ready stretch
// Assumes: address on the lanes while strobe is high; narrow odd bytes on the low lane
// Notes:   released lanes show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       bus_strobe_n,
  input  wire logic       rw_out,
  input  wire logic [7:0] addr_low_out,
  input  wire logic [7:0] mid_lane_out,
  input  wire logic       mid_lane_oe,
  input  wire logic [7:0] low_address_data_lane_out,
  input  wire logic       low_address_data_lane_oe,
  output logic      [7:0] mid_lane_in,
  output logic      [7:0] low_address_data_lane_in,
  output logic            ready_n
);
  logic [23:0] a = '0;
  logic [1:0]  cnt = '0;
  initial mid_lane_in = 8'h00;
  initial low_address_data_lane_in = 8'h00;
  initial ready_n = 1'b1;
  function automatic logic [7:0] mb(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  always @(posedge clk) begin
    if (bus_strobe_n && mid_lane_oe && low_address_data_lane_oe) begin
      a <= {low_address_data_lane_out, mid_lane_out, addr_low_out};
    end
    cnt <= bus_strobe_n ? 2'h0 : (cnt == 2'h3 ? 2'h3 : cnt + 2'h1);
    // Slow mode stretches the data term a few clocks
    ready_n <= !(slow && !bus_strobe_n && cnt < 2'h3);
    if (!bus_strobe_n && rw_out && !low_address_data_lane_oe) begin
      mid_lane_in <= mb({a[23:1], 1'b1});
      low_address_data_lane_in <= mb(a);
    end else begin
      // Never leave a stale value that could pass for data
      mid_lane_in <= ~mid_lane_in;
      low_address_data_lane_in <= ~low_address_data_lane_in;
    end
  end
endmodule  // ebc_mem_model
`default_nettype wire

// [tb/external_bus_hold_ready_control_bench.sv]
// Purpose: self-checking bench for the external bus control block
// Assumes: microprocessor mode on a 16-bit bus, then evaluation mode on an 8-bit bus
// Notes:   CPU read data is checked from a queue by a monitor process
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_ready_control_bench;
  logic clk = 0, rstn = 0, slow = 0, tog_on = 0, no_strobe = 0, pclk = 0, ev_on = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, addr_low_out, mid_lane_in, mid_lane_out;
  logic [7:0] low_address_data_lane_in, low_address_data_lane_out;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, auxiliary_port_out, auxiliary_port_oe, ev_exp;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phi_fall;
  logic mode_select_pin = 0, byte_width_pin = 0, hold_req_n = 1, ready_n, hold_grant_n, bus_strobe_n;
  logic rw_out, upper_byte_enable_n, ctrl_pins_oe, mid_lane_oe, low_address_data_lane_oe;
  logic clock_out_pin, clock_out_oe, debug_control_in = 0, req_valid = 0, req_ready, req_write = 0;
  logic req_word = 0, req_internal = 0, rsp_valid, start_valid, wait_instruction = 0;
  logic stop_instruction = 0, cpu_m_flag = 0, cpu_x_flag = 0, cpu_x_in_use = 0, cpu_queue_flush = 0;
  logic cpu_data_buf_access = 0, cpu_opcode_fetch = 0, cpu_program_fetch = 0;
  logic [23:0] req_addr = 0, start_addr;
  logic [15:0] req_wdata = 0, internal_rdata = 0, rsp_rdata;
  logic [31:0] q[$];
  int          n_fail = 0, checked = 0;

  ebc_bus_ctrl  i_ebc_bus_ctrl (.*);
  ebc_mem_model i_ebc_mem_model (.*);

  initial forever #4 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  always @(posedge clk) begin
    {cpu_m_flag, cpu_x_flag, cpu_x_in_use, cpu_queue_flush, cpu_data_buf_access, cpu_opcode_fetch,
     cpu_program_fetch, debug_control_in} <= 8'($urandom);
  end
  // ----------------------------------------
  // Tasks and monitors
  // ----------------------------------------
  function automatic logic [7:0] mb(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(negedge clk);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
    @(posedge clk);
    s_axi_bready <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 0;
    do @(negedge clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    @(posedge clk);
    s_axi_rready <= 0;
  endtask
  task automatic cpu(input logic in);
    logic [15:0] r;
    logic [23:0] a;
    r = 16'($urandom);
    a = 24'($urandom) & 24'h00FFFE;
    @(posedge clk);
    req_addr <= a;
    req_internal <= in;
    req_word <= 1;
    internal_rdata <= r;
    req_valid <= 1;
    q.push_back(in ? {16'h0, r} : {16'h0, mb(a | 24'h1), mb(a)});
    do @(negedge clk); while (!req_ready);
    @(posedge clk);
    req_valid <= 0;
    while (q.size() != 0) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) chk(rsp_rdata, q.size() != 0 ? q.pop_front() : 32'hDEAD);
    if (start_valid === 1'b1) chk(start_addr, {8'h00, mb(24'h00FFFF), mb(24'h00FFFE)});
    if (tog_on) chk(clock_out_pin, !pclk);
    if (no_strobe) chk(bus_strobe_n, 1);
    if (ev_on) chk({auxiliary_port_oe, auxiliary_port_out}, {4'hF, ev_exp});
    ev_exp <= {cpu_program_fetch, cpu_data_buf_access | cpu_opcode_fetch, cpu_queue_flush,
               cpu_x_in_use ? cpu_x_flag : cpu_m_flag};
    pclk <= clock_out_pin;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3c1ee9b9));
    repeat (3) @(posedge clk);
    chk({hold_grant_n, bus_strobe_n}, 2'h3);
    rstn <= 1;
    wait (start_valid === 1'b1);
    axi_rd(ebc_pkg::REG_START, {16'h0, mb(24'h00FFFF), mb(24'h00FFFE)}, ebc_pkg::RESP_OKAY);
    axi_wr(ebc_pkg::REG_CTRL, 32'hFFFFFFFF, ebc_pkg::RESP_OKAY);
    axi_rd(ebc_pkg::REG_CTRL, 32'h1F, ebc_pkg::RESP_OKAY);
    axi_rd(8'h10, 32'h0, ebc_pkg::RESP_SLVERR);
    axi_wr(8'h10, 32'h1, ebc_pkg::RESP_SLVERR);
    repeat (3) @(negedge clk);
    chk({clock_out_pin, clock_out_oe}, 2'h3);
    no_strobe = 1;
    cpu(1);
    no_strobe = 0;
    stop_instruction <= 1;
    repeat (6) @(negedge clk);
    chk(bus_strobe_n, 0);
    axi_wr(ebc_pkg::REG_CTRL, 32'h0, ebc_pkg::RESP_OKAY);
    {wait_instruction, stop_instruction} <= 2'h2;
    repeat (6) @(negedge clk);
    chk(bus_strobe_n, 1);
    wait_instruction <= 0;
    tog_on = 1;
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      if (i == 3) axi_wr(ebc_pkg::REG_CTRL, 32'h10, ebc_pkg::RESP_OKAY);
      cpu(i == 5);
    end
    tog_on = 0;
    slow <= 0;
    @(posedge clk);
    hold_req_n <= 0;
    do @(negedge clk); while (hold_grant_n !== 1'b0);
    chk(ctrl_pins_oe, 1);
    @(negedge clk);
    chk(ctrl_pins_oe, 1);
    @(negedge clk);
    chk({ctrl_pins_oe, mid_lane_oe, low_address_data_lane_oe}, 3'h0);
    repeat (5) @(negedge clk) chk(hold_grant_n, 0);
    @(posedge clk);
    hold_req_n <= 1;
    do @(negedge clk); while (hold_grant_n !== 1'b1);
    chk(ctrl_pins_oe, 0);
    @(negedge clk);
    chk(ctrl_pins_oe, 0);
    @(negedge clk);
    chk({ctrl_pins_oe, mid_lane_oe, low_address_data_lane_oe}, 3'h7);
    cpu(0);
    rstn <= 0;
    mode_select_pin <= 1;
    byte_width_pin <= 1;
    repeat (3) @(posedge clk);
    chk({hold_grant_n, bus_strobe_n}, 2'h3);
    rstn <= 1;
    wait (start_valid === 1'b1);
    axi_wr(ebc_pkg::REG_CTRL, 32'h1, ebc_pkg::RESP_OKAY);
    ev_on <= 1;
    tog_on <= 1;
    cpu(0);
    wrap_up();
  end
endmodule  // external_bus_hold_ready_control_bench
`default_nettype wire
